// File: hdl/poc_pkg.sv
package poc_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_POWER = 6'h1e;
  localparam logic [5:0] IDX_OSEL1 = 6'h1f;
  localparam logic [5:0] IDX_OSEL2 = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h28;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Reset values and writable bits
  localparam logic [7:0] POWER_RST = 8'h30;
  localparam logic [7:0] OSEL1_RST = 8'h14;
  localparam logic [7:0] OSEL2_RST = 8'h08;
  localparam logic [7:0] POWER_MASK = 8'h3f;
  localparam logic [7:0] OSEL1_MASK = 8'h7f;
  localparam logic [7:0] OSEL2_MASK = 8'hfc;

  // Power register fields
  localparam int PWR_BW = 5;
  localparam int PWR_AUTO = 4;
  localparam int PWR_FORCE = 3;
  localparam int PWR_PIN_POL = 2;
  localparam int PWR_FAST = 1;
  localparam int PWR_SOG_PD = 0;

  // First output-select fields
  localparam int OS1_MODE_HI = 6;
  localparam int OS1_MODE_LO = 5;
  localparam int OS1_PRI = 4;
  localparam int OS1_SEC = 3;
  localparam int OS1_DRV_HI = 2;
  localparam int OS1_DRV_LO = 1;
  localparam int OS1_CLK_INV = 0;

  // Second output-select fields
  localparam int OS2_CLK_HI = 7;
  localparam int OS2_CLK_LO = 6;
  localparam int OS2_HIZ = 5;
  localparam int OS2_SOG_HIZ = 4;
  localparam int OS2_FIELD_POL = 3;
  localparam int OS2_PLL_FILT = 2;

  // Status fields
  localparam int STS_PIN = 0;
  localparam int STS_REQ = 1;
  localparam int STS_DOWN = 2;
  localparam int STS_HIZ = 3;
  localparam int STS_MODE_BAD = 4;

  // Gated output groups
  localparam int NUM_OUT = 4;
  localparam int OUT_PRI = 0;
  localparam int OUT_SEC = 1;
  localparam int OUT_DCLK = 2;
  localparam int OUT_VSYNC = 3;
  localparam logic [1:0] VSYNC_DRIVE = 2'h3;

  typedef enum logic [1:0] {
    MODE_444 = 2'b00,
    MODE_422 = 2'b01,
    MODE_DDR = 2'b10,
    MODE_RSVD = 2'b11
  } poc_mode_t;

  typedef enum logic [2:0] {
    PS_RUN = 3'b001,
    PS_HIZ = 3'b010,
    PS_DOWN = 3'b100
  } poc_pwr_state_t;

endpackage: poc_pkg

// File: hdl/poc_pd_ctl.sv
`timescale 1ns/10ps
`default_nettype none
module poc_pd_ctl (
  // Pin and its polarity
  input wire logic pin,
  input wire logic pin_active_high,
  // Register controls and sync presence
  input wire logic auto_mode,
  input wire logic force_down,
  input wire logic sync_present,
  // Decoded requests
  output logic pin_asserted,
  output logic pd_request
);

  // Pin is active when it matches the programmed level
  assign pin_asserted = (pin == pin_active_high);

  // Auto mode adds loss of sync as a cause; pin and bit act in both
  assign pd_request = force_down | pin_asserted
                    | (auto_mode & ~sync_present);

endmodule: poc_pd_ctl
`default_nettype wire

// File: hdl/poc_clk_sel.sv
`timescale 1ns/10ps
`default_nettype none
module poc_clk_sel (
  // Clock and control
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Selection
  input wire logic [1:0] sel,
  input wire logic invert,
  // Clock sources, sampled as levels
  input wire logic [3:0] src,
  // Selected clock level
  output logic dclk
);

  // Registered so a select change cannot glitch the pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dclk <= 1'b0;
    end else if (ce) begin
      dclk <= src[sel] ^ invert;
    end
  end

endmodule: poc_clk_sel
`default_nettype wire

// File: hdl/poc_regs.sv
// Notes on behaviour
// - Power bit 5 picks analog bandwidth: 0 low, 1 high.
// - Power bit 4 picks manual (0) or automatic (1) power-down; reset 1.
// - Power bit 3 set forces power-down; clear runs normally; reset 0.
// - Power bit 2 sets power-down pin level: 0 active low, 1 high.
// - Power bit 1 set: power-down keeps core up, only outputs float.
// - Power bit 0 set floats the sync monitor pin during power-down.
// - Mode field 6:5: 00 is 4:4:4, 01 is 4:2:2, 10 is DDR.
// - Select-one bit 4 enables primary bus, else floats; reset enabled.
// - Select-one bit 3 enables secondary bus, else floats; reset off.
// - Bits 2:1 set drive strength for all but vertical sync.
// - Select-one bit 0 inverts the data clock output.
// - Select-two bits 7:6 pick data clock: pixel, 90, 2x, internal.
// - Select-two bit 5 floats every output except sync monitor.
// - Select-two bit 4 floats the sync monitor pin.
// - Select-two bit 3 swaps field output polarity; reset 1.
// - Select-two bit 2 makes the PLL follow filtered horizontal sync.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module poc_regs (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Power-down inputs
  input wire logic PWRDN_PIN,
  input wire logic SYNC_PRESENT,
  // Clock sources and sync levels
  input wire logic PIXEL_CLOCK,
  input wire logic PIXEL_CLOCK_90,
  input wire logic PIXEL_CLOCK_2X,
  input wire logic INTERNAL_CLOCK,
  input wire logic FIELD_ODD,
  input wire logic RAW_HSYNC,
  input wire logic FILTERED_HSYNC,
  // Configuration outputs
  output logic HIGH_BANDWIDTH,
  output logic CORE_POWER_DOWN,
  output logic [1:0] OUTPUT_MODE,
  output logic MODE_RESERVED,
  output logic [1:0] DRIVE_STRENGTH,
  output logic [1:0] VSYNC_DRIVE_STRENGTH,
  output logic DATA_CLOCK_OUT,
  output logic FIELD_OUT,
  output logic PLL_HSYNC,
  // Output enables, low while driving
  output logic PRIMARY_OE_N,
  output logic SECONDARY_OE_N,
  output logic DATA_CLOCK_OE_N,
  output logic VERTICAL_SYNC_OE_N,
  output logic SYNC_MONITOR_OE_N
);

  logic [7:0] power;
  logic [7:0] osel1;
  logic [7:0] osel2;
  logic [5:0] idx;
  logic rd_hit;
  logic bad_addr;
  logic data_ready;
  logic access_done;
  logic wr_take;
  logic [31:0] rd_word;
  logic pin_asserted;
  logic pd_request;
  logic [3:0] clk_src;
  logic [poc_pkg::NUM_OUT-1:0] out_en;
  logic [poc_pkg::NUM_OUT-1:0] oe_n;
  logic sync_mon_hiz;
  poc_pkg::poc_pwr_state_t state;
  poc_pkg::poc_pwr_state_t next_state;

  // Address decode; status is the only read-only word
  assign idx = PADDR[7:2];
  assign bad_addr = (PADDR[1:0] != poc_pkg::WORD_ALIGN) || !rd_hit;
  assign PREADY = CE & data_ready;
  assign access_done = PSEL & PENABLE & PREADY;
  assign PSLVERR = PSEL & PENABLE & bad_addr;
  assign wr_take = access_done & PWRITE & ~bad_addr & PSTRB[0];

  // Read mux; upper bits read zero, status shows live state
  always_comb begin
    rd_word = poc_pkg::RD_ZERO;
    rd_hit = 1'b1;
    case (idx)
      poc_pkg::IDX_POWER: rd_word = 32'(power);
      poc_pkg::IDX_OSEL1: rd_word = 32'(osel1);
      poc_pkg::IDX_OSEL2: rd_word = 32'(osel2);
      poc_pkg::IDX_STATUS: begin
        rd_word[poc_pkg::STS_PIN] = pin_asserted;
        rd_word[poc_pkg::STS_REQ] = pd_request;
        rd_word[poc_pkg::STS_DOWN] = (state == poc_pkg::PS_DOWN);
        rd_word[poc_pkg::STS_HIZ] = (state == poc_pkg::PS_HIZ);
        rd_word[poc_pkg::STS_MODE_BAD] = MODE_RESERVED;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data is caught in setup so it comes from a flop in access
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      data_ready <= 1'b0;
      PRDATA <= poc_pkg::RD_ZERO;
    end else if (CE) begin
      data_ready <= PSEL & ~access_done;
      if (PSEL && !access_done) begin
        PRDATA <= bad_addr ? poc_pkg::RD_ZERO : rd_word;
      end
    end
  end

  // Register writes; only the low byte lane carries data
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      power <= poc_pkg::POWER_RST;
      osel1 <= poc_pkg::OSEL1_RST;
      osel2 <= poc_pkg::OSEL2_RST;
    end else if (CE && wr_take) begin
      if (idx == poc_pkg::IDX_POWER) begin
        power <= PWDATA[7:0] & poc_pkg::POWER_MASK;
      end
      if (idx == poc_pkg::IDX_OSEL1) begin
        osel1 <= PWDATA[7:0] & poc_pkg::OSEL1_MASK;
      end
      if (idx == poc_pkg::IDX_OSEL2) begin
        osel2 <= PWDATA[7:0] & poc_pkg::OSEL2_MASK;
      end
    end
  end

  // Power-down causes
  poc_pd_ctl u_pd_ctl (
    .pin(PWRDN_PIN),
    .pin_active_high(power[poc_pkg::PWR_PIN_POL]),
    .auto_mode(power[poc_pkg::PWR_AUTO]),
    .force_down(power[poc_pkg::PWR_FORCE]),
    .sync_present(SYNC_PRESENT),
    .pin_asserted(pin_asserted),
    .pd_request(pd_request)
  );

  // Fast switching trades power saving for instant wake
  always_comb begin
    next_state = poc_pkg::PS_RUN;
    if (pd_request) begin
      next_state = power[poc_pkg::PWR_FAST] ? poc_pkg::PS_HIZ
                                            : poc_pkg::PS_DOWN;
    end
  end

  // Power state
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= poc_pkg::PS_RUN;
    end else if (CE) begin
      state <= next_state;
    end
  end

  assign CORE_POWER_DOWN = (state == poc_pkg::PS_DOWN);

  // Per-output enable bits; clock and vertical sync have none
  assign out_en[poc_pkg::OUT_PRI] = osel1[poc_pkg::OS1_PRI];
  assign out_en[poc_pkg::OUT_SEC] = osel1[poc_pkg::OS1_SEC];
  assign out_en[poc_pkg::OUT_DCLK] = 1'b1;
  assign out_en[poc_pkg::OUT_VSYNC] = 1'b1;

  // Enables float on bus disable, global float or any power-down
  for (genvar i = 0; i < poc_pkg::NUM_OUT; i++) begin : g_oe
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        oe_n[i] <= 1'b1;
      end else if (CE) begin
        oe_n[i] <= ~(out_en[i] & ~osel2[poc_pkg::OS2_HIZ]
                   & (state == poc_pkg::PS_RUN));
      end
    end
  end

  assign PRIMARY_OE_N = oe_n[poc_pkg::OUT_PRI];
  assign SECONDARY_OE_N = oe_n[poc_pkg::OUT_SEC];
  assign DATA_CLOCK_OE_N = oe_n[poc_pkg::OUT_DCLK];
  assign VERTICAL_SYNC_OE_N = oe_n[poc_pkg::OUT_VSYNC];

  // Sync monitor ignores the global float, so it can wake a scaler
  assign sync_mon_hiz = osel2[poc_pkg::OS2_SOG_HIZ]
                      | (power[poc_pkg::PWR_SOG_PD]
                         & (state != poc_pkg::PS_RUN));

  // Registered configuration and data outputs
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      SYNC_MONITOR_OE_N <= 1'b1;
      HIGH_BANDWIDTH <= 1'b0;
      OUTPUT_MODE <= poc_pkg::MODE_444;
      MODE_RESERVED <= 1'b0;
      DRIVE_STRENGTH <= 2'h0;
      FIELD_OUT <= 1'b0;
      PLL_HSYNC <= 1'b0;
    end else if (CE) begin
      SYNC_MONITOR_OE_N <= sync_mon_hiz;
      HIGH_BANDWIDTH <= power[poc_pkg::PWR_BW];
      OUTPUT_MODE <= osel1[poc_pkg::OS1_MODE_HI:poc_pkg::OS1_MODE_LO];
      MODE_RESERVED <= osel1[poc_pkg::OS1_MODE_HI:poc_pkg::OS1_MODE_LO]
                       == poc_pkg::MODE_RSVD;
      DRIVE_STRENGTH <= osel1[poc_pkg::OS1_DRV_HI:poc_pkg::OS1_DRV_LO];
      FIELD_OUT <= FIELD_ODD ^ osel2[poc_pkg::OS2_FIELD_POL];
      PLL_HSYNC <= osel2[poc_pkg::OS2_PLL_FILT] ? FILTERED_HSYNC
                                                 : RAW_HSYNC;
    end
  end

  // Vertical sync keeps a fixed strength
  assign VSYNC_DRIVE_STRENGTH = poc_pkg::VSYNC_DRIVE;

  // Clock source order matches the select encoding
  assign clk_src = {INTERNAL_CLOCK, PIXEL_CLOCK_2X,
                    PIXEL_CLOCK_90, PIXEL_CLOCK};

  poc_clk_sel u_clk_sel (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .sel(osel2[poc_pkg::OS2_CLK_HI:poc_pkg::OS2_CLK_LO]),
    .invert(osel1[poc_pkg::OS1_CLK_INV]),
    .src(clk_src),
    .dclk(DATA_CLOCK_OUT)
  );

  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  // Field views for the checks
  logic [1:0] mode_fld;
  logic [1:0] drv_fld;
  logic [1:0] clk_fld;
  assign mode_fld = osel1[poc_pkg::OS1_MODE_HI:poc_pkg::OS1_MODE_LO];
  assign drv_fld = osel1[poc_pkg::OS1_DRV_HI:poc_pkg::OS1_DRV_LO];
  assign clk_fld = osel2[poc_pkg::OS2_CLK_HI:poc_pkg::OS2_CLK_LO];

  sequence s_pd_cause;
    CE && pd_request;
  endsequence

  sequence s_sec_drive;
    CE && osel1[poc_pkg::OS1_SEC] && !osel2[poc_pkg::OS2_HIZ]
    && state == poc_pkg::PS_RUN;
  endsequence

  sequence s_power_write;
    CE && wr_take && idx == poc_pkg::IDX_POWER;
  endsequence

  bandwidth_follow_a: assert property (
    $past(CE) && $past(RESETN)
    |-> HIGH_BANDWIDTH == $past(power[poc_pkg::PWR_BW]))
    else $error("bandwidth output does not follow register");

  auto_pd_a: assert property (
    CE && power[poc_pkg::PWR_AUTO] && !SYNC_PRESENT
    |=> state != poc_pkg::PS_RUN)
    else $error("auto mode did not power down without sync");

  force_pd_a: assert property (
    s_pd_cause ##0 power[poc_pkg::PWR_FORCE] |=> state != poc_pkg::PS_RUN)
    else $error("forced power-down not honoured");

  manual_run_a: assert property (
    CE && !power[poc_pkg::PWR_AUTO] && !power[poc_pkg::PWR_FORCE]
    && PWRDN_PIN != power[poc_pkg::PWR_PIN_POL]
    |=> state == poc_pkg::PS_RUN)
    else $error("device left normal run without cause");

  pin_level_a: assert property (
    CE && PWRDN_PIN == power[poc_pkg::PWR_PIN_POL]
    |=> state != poc_pkg::PS_RUN)
    else $error("power-down pin at active level ignored");

  fast_switch_a: assert property (
    s_pd_cause |=> CORE_POWER_DOWN == !$past(power[poc_pkg::PWR_FAST])
    ##1 (!$past(CE) || PRIMARY_OE_N))
    else $error("fast switching chose the wrong power state");

  sog_pd_a: assert property (
    CE && state != poc_pkg::PS_RUN && power[poc_pkg::PWR_SOG_PD]
    |=> SYNC_MONITOR_OE_N)
    else $error("sync monitor driven in power-down");

  mode_out_a: assert property (
    $past(CE) && $past(RESETN) |-> OUTPUT_MODE == $past(mode_fld)
    && MODE_RESERVED == ($past(mode_fld) == poc_pkg::MODE_RSVD))
    else $error("output mode does not follow register");

  pri_float_a: assert property (
    CE && !osel1[poc_pkg::OS1_PRI] |=> PRIMARY_OE_N)
    else $error("primary bus driven while disabled");

  sec_drive_a: assert property (
    s_sec_drive |=> !SECONDARY_OE_N)
    else $error("secondary bus floats while enabled");

  drive_level_a: assert property (
    $past(CE) && $past(RESETN) |-> DRIVE_STRENGTH == $past(drv_fld)
    && VSYNC_DRIVE_STRENGTH == poc_pkg::VSYNC_DRIVE)
    else $error("drive strength wrong");

  clock_out_a: assert property (
    $past(CE) && $past(RESETN) |-> DATA_CLOCK_OUT
    == ($past(clk_src[clk_fld]) ^ $past(osel1[poc_pkg::OS1_CLK_INV])))
    else $error("data clock source or inversion wrong");

  global_float_a: assert property (
    CE && osel2[poc_pkg::OS2_HIZ] |=> PRIMARY_OE_N && SECONDARY_OE_N
    && DATA_CLOCK_OE_N && VERTICAL_SYNC_OE_N)
    else $error("an output drives under global float");

  sog_float_a: assert property (
    CE && osel2[poc_pkg::OS2_SOG_HIZ] |=> SYNC_MONITOR_OE_N)
    else $error("sync monitor driven while floated");

  field_pol_a: assert property (
    $past(CE) && $past(RESETN) |-> FIELD_OUT == ($past(FIELD_ODD)
    ^ $past(osel2[poc_pkg::OS2_FIELD_POL])))
    else $error("field output polarity wrong");

  pll_source_a: assert property (
    $past(CE) && $past(RESETN)
    |-> PLL_HSYNC == ($past(osel2[poc_pkg::OS2_PLL_FILT])
    ? $past(FILTERED_HSYNC) : $past(RAW_HSYNC)))
    else $error("PLL sync source wrong");

  power_write_a: assert property (
    s_power_write |=> power == ($past(PWDATA[7:0]) & poc_pkg::POWER_MASK))
    else $error("power register write lost");

endmodule: poc_regs
`default_nettype wire

// File: bench/poc_sink.sv
`timescale 1ns/10ps
`default_nettype none
module poc_sink (
  // Receiver clock
  input wire logic clk,
  // Enables seen at the receiver, low while driven
  input wire logic [4:0] oe_n,
  input wire logic dclk,
  // What the receiver resolves on its pins
  output logic [4:0] driven,
  output logic dclk_wire
);
  logic last;

  // Remember the clock line while it is driven
  always_ff @(posedge clk) begin
    if (!oe_n[2]) begin
      last <= dclk;
    end
  end

  // A floated line must not pass for a held level, so show the inverse
  assign driven = ~oe_n;
  assign dclk_wire = oe_n[2] ? ~last : dclk;
endmodule: poc_sink
`default_nettype wire

// File: bench/poc_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module poc_regs_tb;
  // Design inputs
  logic CLK = 1'b0, RESETN = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
  logic PWRITE = 1'b0, PWRDN_PIN = 1'b1, SYNC_PRESENT = 1'b1;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [3:0] PSTRB = 4'hf;
  logic PIXEL_CLOCK = 1'b0, PIXEL_CLOCK_90 = 1'b0, PIXEL_CLOCK_2X = 1'b0;
  logic INTERNAL_CLOCK = 1'b0, FIELD_ODD = 1'b0;
  logic RAW_HSYNC = 1'b0, FILTERED_HSYNC = 1'b0;
  // Design outputs
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, HIGH_BANDWIDTH, CORE_POWER_DOWN, MODE_RESERVED;
  logic [1:0] OUTPUT_MODE, DRIVE_STRENGTH, VSYNC_DRIVE_STRENGTH;
  logic DATA_CLOCK_OUT, FIELD_OUT, PLL_HSYNC, PRIMARY_OE_N, SECONDARY_OE_N;
  logic DATA_CLOCK_OE_N, VERTICAL_SYNC_OE_N, SYNC_MONITOR_OE_N;
  // Bench state and model
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] lfsr = 32'h27ab_9592;
  logic [31:0] rd, r, p;
  logic er;
  logic [7:0] ad[3] = '{8'h78, 8'h7c, 8'h80};
  logic [7:0] mk[3] = '{8'h3f, 8'h7f, 8'hfc};
  logic [7:0] m[3] = '{8'h30, 8'h14, 8'h08};
  logic [4:0] drv;
  logic dwire;
  logic act, req, run, gate;

  poc_regs uut (.CLK, .RESETN, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PSTRB, .PRDATA, .PREADY, .PSLVERR, .PWRDN_PIN, .SYNC_PRESENT,
    .PIXEL_CLOCK, .PIXEL_CLOCK_90, .PIXEL_CLOCK_2X, .INTERNAL_CLOCK,
    .FIELD_ODD, .RAW_HSYNC, .FILTERED_HSYNC, .HIGH_BANDWIDTH,
    .CORE_POWER_DOWN, .OUTPUT_MODE, .MODE_RESERVED, .DRIVE_STRENGTH,
    .VSYNC_DRIVE_STRENGTH, .DATA_CLOCK_OUT, .FIELD_OUT, .PLL_HSYNC,
    .PRIMARY_OE_N, .SECONDARY_OE_N, .DATA_CLOCK_OE_N, .VERTICAL_SYNC_OE_N,
    .SYNC_MONITOR_OE_N);

  poc_sink sink (.clk(CLK), .oe_n({SYNC_MONITOR_OE_N, VERTICAL_SYNC_OE_N,
    DATA_CLOCK_OE_N, SECONDARY_OE_N, PRIMARY_OE_N}), .dclk(DATA_CLOCK_OUT),
    .driven(drv), .dclk_wire(dwire));

  // Free-running 250 MHz clock
  always #2 CLK = ~CLK;

  // Next state of the stimulus register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction: lfsr_next

  task automatic rnd();
    lfsr = lfsr_next(lfsr);
    r = lfsr;
  endtask: rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask: chk

  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Answer and data are taken at the rising edge that sees ready
    while (ok !== 1'b1 && n < 40) begin
      @(posedge CLK);
      ok = PREADY;
      rd = PRDATA;
      er = PSLVERR;
      n++;
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Idle edge, so the next setup never retouches PSEL at once
    @(posedge CLK);
    if (ok !== 1'b1) begin
      chk(32'h0000_0001, 32'h0000_0000);
    end
  endtask: apb

  task automatic rdchk(input int i);
    apb(1'b0, ad[i], 32'h0000_0000, 4'hf);
    chk(rd, {24'h00_0000, m[i]});
  endtask: rdchk

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask: final_report

  // Random levels on the sources, outputs checked one cycle later
  task automatic io_chk(input int cnt);
    for (int k = 0; k < cnt; k++) begin
      rnd();
      p = r;
      {FILTERED_HSYNC, RAW_HSYNC, FIELD_ODD} <= r[6:4];
      {INTERNAL_CLOCK, PIXEL_CLOCK_2X, PIXEL_CLOCK_90, PIXEL_CLOCK} <= r[3:0];
      @(posedge CLK);
      @(negedge CLK);
      chk(DATA_CLOCK_OUT, p[m[2][7:6]] ^ m[1][0]);
      chk({DATA_CLOCK_OE_N, dwire & gate},
          {~gate, gate & (p[m[2][7:6]] ^ m[1][0])});
      chk(FIELD_OUT, p[4] ^ m[2][3]);
      chk(PLL_HSYNC, m[2][2] ? p[6] : p[5]);
      chk(HIGH_BANDWIDTH, m[0][5]);
      chk({MODE_RESERVED, OUTPUT_MODE}, {&m[1][6:5], m[1][6:5]});
      chk({VSYNC_DRIVE_STRENGTH, DRIVE_STRENGTH}, {2'b11, m[1][2:1]});
      @(posedge CLK);
    end
  endtask: io_chk

  initial begin
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    for (int i = 0; i < 3; i++) rdchk(i);
    $display("test reset values done");
    // Unmapped and unaligned places answer with an error and zero
    apb(1'b0, 8'h84, 32'h0000_0000, 4'hf);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h79, 32'hffff_ffff, 4'hf);
    chk({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, ad[1], 32'h0000_0000, 4'he);
    rdchk(1);
    $display("test refusals done");
    for (int i = 0; i < 48; i++) begin
      rnd();
      // Software keeps off the reserved mode, bar a rare probe
      if (r[14:13] == 2'b11 && i % 8 != 7) begin
        r[13] = 1'b0;
      end
      PWRDN_PIN <= r[24];
      SYNC_PRESENT <= r[25];
      for (int j = 0; j < 3; j++) begin
        apb(1'b1, ad[j], {r[31:8], r[8*j+:8]}, 4'hf);
        m[j] = r[8*j+:8] & mk[j];
      end
      // Model the power-down causes before r is reused
      act = (r[24] == m[0][2]);
      req = m[0][3] | act | (m[0][4] & ~r[25]);
      run = ~req;
      gate = run & ~m[2][5];
      for (int j = 0; j < 3; j++) rdchk(j);
      io_chk(6);
      @(negedge CLK);
      chk(CORE_POWER_DOWN, req & ~m[0][1]);
      chk(drv, {~(m[2][4] | (m[0][0] & req)), gate, gate,
                m[1][3] & gate, m[1][4] & gate});
      @(posedge CLK);
      apb(1'b0, 8'ha0, 32'h0000_0000, 4'hf);
      chk(rd, {27'h0, &m[1][6:5], req & m[0][1], req & ~m[0][1],
               req, act});
    end
    $display("test random settings done");
    // Clock enable low freezes outputs and stalls a read
    CE <= 1'b0;
    FIELD_ODD <= ~p[4];
    fork
      apb(1'b0, ad[2], 32'h0000_0000, 4'hf);
      begin
        repeat (3) @(posedge CLK);
        CE <= 1'b1;
        @(negedge CLK);
        chk(FIELD_OUT, p[4] ^ m[2][3]);
      end
    join
    chk(rd, {24'h00_0000, m[2]});
    $display("test clock enable done");
    final_report();
  end

  // Hang guard, about nine times the expected run
  initial begin
    #60000;
    err_count++;
    final_report();
  end
endmodule: poc_regs_tb
`default_nettype wire
